// ### logic/tlsc_limit_shutdown.sv
// Purpose: Limit checking, status and system shutdown linking
// Assumes: Byte register port from a bus engine; readings valid at convDone
// Notes:   Alert is a per-conversion comparator level, also held while a latched diode fault bit is set

`timescale 1ns/1ns
`default_nettype none

module tlsc_limit_shutdown
  import tlsc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrEn,
  input  wire logic [7:0] regWrData,
  input  wire logic       regRdEn,
  output logic [7:0]      regRdData,
  input  wire logic       convDone,
  input  wire logic [7:0] intTempInt,
  input  wire logic [7:0] intTempFrac,
  input  wire logic [7:0] ext1TempInt,
  input  wire logic [7:0] ext1TempFrac,
  input  wire logic [7:0] ext2TempInt,
  input  wire logic [7:0] ext2TempFrac,
  input  wire logic       ext1DiodeFault,
  input  wire logic       ext2DiodeFault,
  input  wire logic       hwShutdownCond,
  output logic            alertN,
  output logic            systemShutdownN,
  output logic            internalCriticalFlag,
  output logic            ext1CriticalFlag,
  output logic            ext2CriticalFlag
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] intHi;
    logic [7:0] intLo;
    logic [7:0] e1HiI;
    logic [7:0] e1LoI;
    logic [7:0] e1HiF;
    logic [7:0] e1LoF;
    logic [7:0] e2HiI;
    logic [7:0] e2LoI;
    logic [7:0] e2HiF;
    logic [7:0] e2LoF;
    logic [7:0] e3HiI;
    logic [7:0] e3LoI;
    logic [7:0] e3HiF;
    logic [7:0] e3LoF;
    logic [7:0] e1Crit;
    logic [7:0] e2Crit;
    logic [7:0] intCrit;
    logic [7:0] hyst;
    logic [7:0] scrA;
    logic [7:0] scrB;
    logic [2:0] link;
    logic [2:0] highFlg;
    logic [2:0] lowFlg;
    logic [2:0] critFlg;
    logic [2:0] shdLatch;
    logic       hwSd;
    logic       alertN;
    logic       shdnN;
    logic [7:0] rdData;
  } tlsc_main_s;

  tlsc_main_s s_reg;
  tlsc_main_s s_next;

  logic [2:0] cmpHigh;
  logic [2:0] cmpLow;
  logic [2:0] cmpCrit;
  logic [2:0] cmpRel;
  logic [7:0] faultByte;
  logic       faultRdClr;
  logic [7:0] statusByte;
  logic [7:0] rdMux;

  // ****************************************************************
  // Channel comparators
  // ****************************************************************
  // Internal channel has integer-only limits, fraction fed as zero
  tlsc_chan_compare u_cmp_int (
    .tempInt      (intTempInt),
    .tempFrac     (intTempFrac),
    .highInt      (s_reg.intHi),
    .highFrac     (RST_FRAC),
    .lowInt       (s_reg.intLo),
    .lowFrac      (RST_FRAC),
    .critLimit    (s_reg.intCrit),
    .hysteresis   (s_reg.hyst),
    .aboveHigh    (cmpHigh[CH_INT]),
    .atOrBelowLow (cmpLow[CH_INT]),
    .aboveCrit    (cmpCrit[CH_INT]),
    .belowRelease (cmpRel[CH_INT])
  );

  tlsc_chan_compare u_cmp_ext1 (
    .tempInt      (ext1TempInt),
    .tempFrac     (ext1TempFrac),
    .highInt      (s_reg.e1HiI),
    .highFrac     (s_reg.e1HiF),
    .lowInt       (s_reg.e1LoI),
    .lowFrac      (s_reg.e1LoF),
    .critLimit    (s_reg.e1Crit),
    .hysteresis   (s_reg.hyst),
    .aboveHigh    (cmpHigh[CH_EXT1]),
    .atOrBelowLow (cmpLow[CH_EXT1]),
    .aboveCrit    (cmpCrit[CH_EXT1]),
    .belowRelease (cmpRel[CH_EXT1])
  );

  tlsc_chan_compare u_cmp_ext2 (
    .tempInt      (ext2TempInt),
    .tempFrac     (ext2TempFrac),
    .highInt      (s_reg.e2HiI),
    .highFrac     (s_reg.e2HiF),
    .lowInt       (s_reg.e2LoI),
    .lowFrac      (s_reg.e2LoF),
    .critLimit    (s_reg.e2Crit),
    .hysteresis   (s_reg.hyst),
    .aboveHigh    (cmpHigh[CH_EXT2]),
    .atOrBelowLow (cmpLow[CH_EXT2]),
    .aboveCrit    (cmpCrit[CH_EXT2]),
    .belowRelease (cmpRel[CH_EXT2])
  );

  assign faultRdClr = regRdEn && (regAddr == OFF_FAULT_SRC);

  tlsc_fault_source u_fault (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .ext1Fault (convDone && ext1DiodeFault),
    .ext2Fault (convDone && ext2DiodeFault),
    .readClear (faultRdClr),
    .faultByte (faultByte)
  );

  // ****************************************************************
  // Summary status and read mux
  // ****************************************************************
  always_comb
  begin
    statusByte               = 8'h00;
    statusByte[ST_HIGH_BIT]  = |s_reg.highFlg;
    statusByte[ST_LOW_BIT]   = |s_reg.lowFlg;
    statusByte[ST_FAULT_BIT] = |faultByte;
    statusByte[ST_CRIT_BIT]  = |s_reg.critFlg;
    statusByte[ST_HWSD_BIT]  = s_reg.hwSd;
  end

  always_comb
  begin
    unique case (regAddr)
      OFF_STATUS:                      rdMux = statusByte;
      OFF_INT_HI, OFF_INT_HI_ALIAS:    rdMux = s_reg.intHi;
      OFF_INT_LO, OFF_INT_LO_ALIAS:    rdMux = s_reg.intLo;
      OFF_E1_HI_INT, OFF_E1_HI_ALIAS:  rdMux = s_reg.e1HiI;
      OFF_E1_LO_INT, OFF_E1_LO_ALIAS:  rdMux = s_reg.e1LoI;
      OFF_SCRATCH_A:                   rdMux = s_reg.scrA;
      OFF_SCRATCH_B:                   rdMux = s_reg.scrB;
      OFF_E1_HI_FRAC:                  rdMux = s_reg.e1HiF;
      OFF_E1_LO_FRAC:                  rdMux = s_reg.e1LoF;
      OFF_E2_HI_INT:                   rdMux = s_reg.e2HiI;
      OFF_E2_LO_INT:                   rdMux = s_reg.e2LoI;
      OFF_E2_HI_FRAC:                  rdMux = s_reg.e2HiF;
      OFF_E2_LO_FRAC:                  rdMux = s_reg.e2LoF;
      OFF_E1_CRIT:                     rdMux = s_reg.e1Crit;
      OFF_E2_CRIT:                     rdMux = s_reg.e2Crit;
      OFF_FAULT_SRC:                   rdMux = faultByte;
      OFF_LINK_CFG:                    rdMux = {5'h00, s_reg.link};
      OFF_INT_CRIT:                    rdMux = s_reg.intCrit;
      OFF_HYST:                        rdMux = s_reg.hyst;
      OFF_E3_HI_INT:                   rdMux = s_reg.e3HiI;
      OFF_E3_LO_INT:                   rdMux = s_reg.e3LoI;
      OFF_E3_HI_FRAC:                  rdMux = s_reg.e3HiF;
      OFF_E3_LO_FRAC:                  rdMux = s_reg.e3LoF;
      default:                         rdMux = 8'h00;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    s_next = s_reg;
    if (regRdEn)
    begin
      s_next.rdData = rdMux;
    end
    if (regWrEn)
    begin
      // Fraction bytes keep only the three weighted bits
      unique case (regAddr)
        OFF_INT_HI, OFF_INT_HI_ALIAS:   s_next.intHi = regWrData;
        OFF_INT_LO, OFF_INT_LO_ALIAS:   s_next.intLo = regWrData;
        OFF_E1_HI_INT, OFF_E1_HI_ALIAS: s_next.e1HiI = regWrData;
        OFF_E1_LO_INT, OFF_E1_LO_ALIAS: s_next.e1LoI = regWrData;
        OFF_SCRATCH_A:  s_next.scrA  = regWrData;
        OFF_SCRATCH_B:  s_next.scrB  = regWrData;
        OFF_E1_HI_FRAC: s_next.e1HiF = {regWrData[7:5], 5'h00};
        OFF_E1_LO_FRAC: s_next.e1LoF = {regWrData[7:5], 5'h00};
        OFF_E2_HI_INT:  s_next.e2HiI = regWrData;
        OFF_E2_LO_INT:  s_next.e2LoI = regWrData;
        OFF_E2_HI_FRAC: s_next.e2HiF = {regWrData[7:5], 5'h00};
        OFF_E2_LO_FRAC: s_next.e2LoF = {regWrData[7:5], 5'h00};
        OFF_E1_CRIT:    s_next.e1Crit = regWrData;
        OFF_E2_CRIT:    s_next.e2Crit = regWrData;
        OFF_LINK_CFG:   s_next.link   = regWrData[2:0];
        OFF_INT_CRIT:   s_next.intCrit = regWrData;
        OFF_HYST:       s_next.hyst    = regWrData;
        OFF_E3_HI_INT:  s_next.e3HiI = regWrData;
        OFF_E3_LO_INT:  s_next.e3LoI = regWrData;
        OFF_E3_HI_FRAC: s_next.e3HiF = {regWrData[7:5], 5'h00};
        OFF_E3_LO_FRAC: s_next.e3LoF = {regWrData[7:5], 5'h00};
        default: ;
      endcase
    end
    if (convDone)
    begin
      s_next.highFlg = cmpHigh;
      s_next.lowFlg  = cmpLow;
      s_next.critFlg = cmpCrit;
      for (int ch = 0; ch < 3; ch++)
      begin
        // Latch arms only on linked channels; released by hysteresis
        if (cmpCrit[ch] && s_next.link[ch])
        begin
          s_next.shdLatch[ch] = 1'b1;
        end
        else if (cmpRel[ch] || !s_next.link[ch])
        begin
          s_next.shdLatch[ch] = 1'b0;
        end
      end
    end
    s_next.hwSd   = hwShutdownCond;
    // Alert includes faults latched this cycle so none is missed
    s_next.alertN = !((|s_next.highFlg) || (|s_next.lowFlg) ||
                      (|faultByte) || (convDone &&
                      (ext1DiodeFault || ext2DiodeFault)));
    s_next.shdnN  = !((|(s_next.shdLatch & s_next.link)) ||
                      hwShutdownCond);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      s_reg         <= '0;
      s_reg.intHi   <= RST_HIGH_LIMIT;
      s_reg.intLo   <= RST_LOW_LIMIT;
      s_reg.e1HiI   <= RST_HIGH_LIMIT;
      s_reg.e1LoI   <= RST_LOW_LIMIT;
      s_reg.e1HiF   <= RST_FRAC;
      s_reg.e1LoF   <= RST_FRAC;
      s_reg.e2HiI   <= RST_HIGH_LIMIT;
      s_reg.e2LoI   <= RST_LOW_LIMIT;
      s_reg.e2HiF   <= RST_FRAC;
      s_reg.e2LoF   <= RST_FRAC;
      s_reg.e3HiI   <= RST_HIGH_LIMIT;
      s_reg.e3LoI   <= RST_LOW_LIMIT;
      s_reg.e3HiF   <= RST_FRAC;
      s_reg.e3LoF   <= RST_FRAC;
      s_reg.e1Crit  <= RST_CRIT_LIMIT;
      s_reg.e2Crit  <= RST_CRIT_LIMIT;
      s_reg.intCrit <= RST_CRIT_LIMIT;
      s_reg.hyst    <= RST_HYST;
      s_reg.scrA    <= RST_SCRATCH;
      s_reg.scrB    <= RST_SCRATCH;
      s_reg.link    <= RST_LINK;
      s_reg.alertN  <= 1'b1;
      s_reg.shdnN   <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign regRdData            = s_reg.rdData;
  assign alertN               = s_reg.alertN;
  assign systemShutdownN      = s_reg.shdnN;
  assign internalCriticalFlag = s_reg.critFlg[CH_INT];
  assign ext1CriticalFlag     = s_reg.critFlg[CH_EXT1];
  assign ext2CriticalFlag     = s_reg.critFlg[CH_EXT2];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence s_wr_alias;
    regWrEn && regAddr == OFF_INT_HI_ALIAS;
  endsequence
  sequence s_rd_main;
    regRdEn && !regWrEn && regAddr == OFF_INT_HI;
  endsequence

  a_high_flag_set: assert property (convDone && cmpHigh[CH_EXT1]
    |=> s_reg.highFlg[CH_EXT1] && !alertN)
    else $error("high violation not flagged");
  a_low_flag_set: assert property (convDone && cmpLow[CH_INT]
    |=> s_reg.lowFlg[CH_INT] && statusByte[ST_LOW_BIT] && !alertN)
    else $error("low violation not flagged");
  a_alias_same: assert property (s_wr_alias ##1 !regWrEn ##1 s_rd_main
    |=> regRdData == $past(regWrData, 3))
    else $error("aliased limit address differs");
  a_scratch_echo: assert property (regWrEn && regAddr == OFF_SCRATCH_A
    ##1 !regWrEn ##1 regRdEn && !regWrEn && regAddr == OFF_SCRATCH_A
    |=> regRdData == $past(regWrData, 3))
    else $error("scratch read differs from write");
  a_unlinked_quiet: assert property ($past(s_reg.shdLatch) == 3'h0
    && s_reg.shdLatch == 3'h0 && !$past(hwShutdownCond)
    |-> systemShutdownN)
    else $error("shutdown without cause");
  a_linked_shdn: assert property (convDone && cmpCrit[CH_EXT2]
    && s_reg.link[CH_EXT2] && !(regWrEn && regAddr == OFF_LINK_CFG)
    |=> !systemShutdownN && ext2CriticalFlag)
    else $error("linked critical did not shut down");
  a_shdn_hold: assert property (s_reg.shdLatch[CH_INT]
    && s_reg.link[CH_INT] && !convDone
    |=> s_reg.shdLatch[CH_INT])
    else $error("shutdown released between conversions");
  a_hw_shdn: assert property (hwShutdownCond |=> !systemShutdownN)
    else $error("hardware shutdown ignored");
  a_flags_steady: assert property (!convDone
    |=> $stable(s_reg.highFlg) && $stable(s_reg.critFlg))
    else $error("flags changed without conversion");

endmodule

`default_nettype wire

// ### logic/tlsc_pkg.sv
// Purpose: Constants for the temperature limit and shutdown compare block
// Assumes: Byte-wide register port supplied by an external bus engine
// Notes:   Offsets are byte register addresses on the management bus

`default_nettype none

package tlsc_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFF_STATUS        = 8'h02;
  localparam logic [7:0] OFF_INT_HI        = 8'h05;
  localparam logic [7:0] OFF_INT_HI_ALIAS  = 8'h0B;
  localparam logic [7:0] OFF_INT_LO        = 8'h06;
  localparam logic [7:0] OFF_INT_LO_ALIAS  = 8'h0C;
  localparam logic [7:0] OFF_E1_HI_INT     = 8'h07;
  localparam logic [7:0] OFF_E1_HI_ALIAS   = 8'h0D;
  localparam logic [7:0] OFF_E1_LO_INT     = 8'h08;
  localparam logic [7:0] OFF_E1_LO_ALIAS   = 8'h0E;
  localparam logic [7:0] OFF_SCRATCH_A     = 8'h11;
  localparam logic [7:0] OFF_SCRATCH_B     = 8'h12;
  localparam logic [7:0] OFF_E1_HI_FRAC    = 8'h13;
  localparam logic [7:0] OFF_E1_LO_FRAC    = 8'h14;
  localparam logic [7:0] OFF_E2_HI_INT     = 8'h15;
  localparam logic [7:0] OFF_E2_LO_INT     = 8'h16;
  localparam logic [7:0] OFF_E2_HI_FRAC    = 8'h17;
  localparam logic [7:0] OFF_E2_LO_FRAC    = 8'h18;
  localparam logic [7:0] OFF_E1_CRIT       = 8'h19;
  localparam logic [7:0] OFF_E2_CRIT       = 8'h1A;
  localparam logic [7:0] OFF_FAULT_SRC     = 8'h1B;
  localparam logic [7:0] OFF_LINK_CFG      = 8'h1D;
  localparam logic [7:0] OFF_INT_CRIT      = 8'h20;
  localparam logic [7:0] OFF_HYST          = 8'h21;
  localparam logic [7:0] OFF_E3_HI_INT     = 8'h2C;
  localparam logic [7:0] OFF_E3_LO_INT     = 8'h2D;
  localparam logic [7:0] OFF_E3_HI_FRAC    = 8'h2E;
  localparam logic [7:0] OFF_E3_LO_FRAC    = 8'h2F;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_HIGH_LIMIT    = 8'h55;
  localparam logic [7:0] RST_LOW_LIMIT     = 8'h00;
  localparam logic [7:0] RST_FRAC          = 8'h00;
  localparam logic [7:0] RST_CRIT_LIMIT    = 8'h55;
  localparam logic [7:0] RST_HYST          = 8'h0A;
  localparam logic [7:0] RST_SCRATCH       = 8'h00;
  localparam logic [2:0] RST_LINK          = 3'h0;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CH_INT        = 0;
  localparam int CH_EXT1       = 1;
  localparam int CH_EXT2       = 2;
  localparam int ST_HIGH_BIT   = 4;
  localparam int ST_LOW_BIT    = 3;
  localparam int ST_FAULT_BIT  = 2;
  localparam int ST_CRIT_BIT   = 1;
  localparam int ST_HWSD_BIT   = 0;
  localparam int FLT_E2_BIT    = 2;
  localparam int FLT_E1_BIT    = 1;
  localparam int FRAC_MSB      = 7;
  localparam int FRAC_LSB      = 5;

  // Integer byte plus three fraction bits, order-preserving in both ranges
  function automatic logic [10:0] tlsc_fixed(input logic [7:0] intByte,
                                             input logic [7:0] fracByte);
    return {intByte, fracByte[FRAC_MSB:FRAC_LSB]};
  endfunction

endpackage

`default_nettype wire

// ### logic/tlsc_chan_compare.sv
// Purpose: Limit, critical and release comparisons for one channel
// Assumes: Reading and limits share the selected range encoding
// Notes:   Pure combinational; the caller samples on conversion done

`timescale 1ns/1ns
`default_nettype none

module tlsc_chan_compare
  import tlsc_pkg::*;
(
  input  wire logic [7:0] tempInt,
  input  wire logic [7:0] tempFrac,
  input  wire logic [7:0] highInt,
  input  wire logic [7:0] highFrac,
  input  wire logic [7:0] lowInt,
  input  wire logic [7:0] lowFrac,
  input  wire logic [7:0] critLimit,
  input  wire logic [7:0] hysteresis,
  output logic            aboveHigh,
  output logic            atOrBelowLow,
  output logic            aboveCrit,
  output logic            belowRelease
);

  logic [10:0] tempFix;
  logic [7:0]  releaseInt;

  // Offset binary keeps unsigned order, so one compare serves both ranges
  assign tempFix      = tlsc_fixed(tempInt, tempFrac);
  assign aboveHigh    = tempFix > tlsc_fixed(highInt, highFrac);
  assign atOrBelowLow = tempFix <= tlsc_fixed(lowInt, lowFrac);
  assign aboveCrit    = tempFix > tlsc_fixed(critLimit, RST_FRAC);
  // Clamp at zero so a large hysteresis cannot wrap round
  assign releaseInt   = (critLimit >= hysteresis) ?
                        (critLimit - hysteresis) : 8'h00;
  assign belowRelease = tempFix < tlsc_fixed(releaseInt, RST_FRAC);

endmodule

`default_nettype wire

// ### logic/tlsc_fault_source.sv
// Purpose: External diode fault source register, cleared by a read
// Assumes: Fault pulses and read pulses are one clock wide
// Notes:   A fault in the clearing cycle survives the clear

`timescale 1ns/1ns
`default_nettype none

module tlsc_fault_source
  import tlsc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       ext1Fault,
  input  wire logic       ext2Fault,
  input  wire logic       readClear,
  output logic [7:0]      faultByte
);

  typedef struct packed {
    logic [7:0] src;
  } tlsc_flt_s;

  tlsc_flt_s s_reg;
  tlsc_flt_s s_next;

  always_comb
  begin
    s_next = s_reg;
    if (readClear)
    begin
      s_next.src = 8'h00;
    end
    // Set after clear so a same-cycle fault wins
    if (ext1Fault)
    begin
      s_next.src[FLT_E1_BIT] = 1'b1;
    end
    if (ext2Fault)
    begin
      s_next.src[FLT_E2_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign faultByte = s_reg.src;

  a_fault_rdclr: assert property (@(posedge clk_sys) disable iff (!resetn)
    readClear && !ext1Fault && !ext2Fault |=> faultByte == 8'h00)
    else $error("fault source not cleared by read");
  a_fault_only: assert property (@(posedge clk_sys) disable iff (!resetn)
    faultByte[7:3] == 5'h00 && faultByte[0] == 1'b0)
    else $error("fault source unused bit set");

endmodule

`default_nettype wire

// ### verif/tlsc_conv_model.sv
// Purpose: Conversion source driving readings and diode fault reports
// Assumes: One reading set per convDone pulse
// Notes:   Inputs scrambled between pulses so stale sampling shows

`timescale 1ns/1ns
`default_nettype none

module tlsc_conv_model
(
  input  wire logic       clk_sys,
  output logic            convDone,
  output logic [7:0]      intTempInt,
  output logic [7:0]      intTempFrac,
  output logic [7:0]      ext1TempInt,
  output logic [7:0]      ext1TempFrac,
  output logic [7:0]      ext2TempInt,
  output logic [7:0]      ext2TempFrac,
  output logic            ext1DiodeFault,
  output logic            ext2DiodeFault
);
  logic [47:0] rdg = 48'h0;
  logic [1:0]  flt = 2'h0;
  initial convDone = 1'h0;
  assign {intTempInt, intTempFrac, ext1TempInt, ext1TempFrac, ext2TempInt,
          ext2TempFrac} = rdg;
  assign {ext2DiodeFault, ext1DiodeFault} = flt;

  task automatic convert(input logic [47:0] t, input logic [1:0] f);
    @(posedge clk_sys);
    convDone <= 1'h1;
    rdg      <= t;
    flt      <= f;
    @(posedge clk_sys);
    convDone <= 1'h0;
    rdg      <= ~t;
    flt      <= ~f;
  endtask
endmodule

`default_nettype wire

// ### verif/tlsc_limit_shutdown_tb.sv
// Purpose: Self-checking bench for limit compare and shutdown linking
// Assumes: Default plain binary range, limits left at reset values
// Notes:   Readings come from the conversion source model

`timescale 1ns/1ns
`default_nettype none

module tlsc_limit_shutdown_tb
  import tlsc_pkg::*;
;
  logic clk_sys, resetn, regWrEn, regRdEn, convDone, hwShutdownCond;
  logic ext1DiodeFault, ext2DiodeFault, alertN, systemShutdownN;
  logic internalCriticalFlag, ext1CriticalFlag, ext2CriticalFlag;
  logic [7:0] regAddr, regWrData, regRdData, intTempInt, intTempFrac;
  logic [7:0] ext1TempInt, ext1TempFrac, ext2TempInt, ext2TempFrac;
  integer n_mismatch = 0;
  integer compares = 0;
  integer seed = 76550;
  localparam logic [7:0] LK [7] = '{8'h02, 8'h02, 8'h02, 8'h01, 8'h01,
                                    8'h04, 8'h04};
  localparam logic [23:0] TV [7] = '{24'h305630, 24'h304B30, 24'h304A30,
    24'h563030, 24'h303030, 24'h303056, 24'h303000};
  localparam logic [6:0] SDX = 7'h54;

  tlsc_limit_shutdown i_dut (
    .clk_sys, .resetn, .regAddr, .regWrEn, .regWrData, .regRdEn,
    .regRdData, .convDone, .intTempInt, .intTempFrac, .ext1TempInt,
    .ext1TempFrac, .ext2TempInt, .ext2TempFrac, .ext1DiodeFault,
    .ext2DiodeFault, .hwShutdownCond, .alertN, .systemShutdownN,
    .internalCriticalFlag, .ext1CriticalFlag, .ext2CriticalFlag);
  tlsc_conv_model i_conv (
    .clk_sys, .convDone, .intTempInt, .intTempFrac, .ext1TempInt,
    .ext1TempFrac, .ext2TempInt, .ext2TempFrac, .ext1DiodeFault,
    .ext2DiodeFault);

  initial
  begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Reading strictly above a limit, fraction in bits 7:5
  function automatic logic hot(input logic [7:0] t, f, l);
    return {t, f[7:5]} > {l, 3'h0};
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'h1;
    @(posedge clk_sys);
    regWrEn   <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, e);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'h1;
    @(posedge clk_sys);
    regRdEn <= 1'h0;
    #1;
    chk($sformatf("reg %h", a), e, regRdData);
  endtask

  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    logic [47:0] t;
    logic [7:0]  d;
    logic [2:0]  cx, lx;
    {resetn, regWrEn, regRdEn, hwShutdownCond} = 4'h0;
    {regAddr, regWrData} = 16'h0;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'h1;
    rd(OFF_INT_HI, RST_HIGH_LIMIT);
    rd(OFF_E2_LO_FRAC, RST_FRAC);
    rd(OFF_E1_CRIT, RST_CRIT_LIMIT);
    rd(OFF_HYST, RST_HYST);
    rd(OFF_LINK_CFG, 8'h00);
    rd(OFF_SCRATCH_B, RST_SCRATCH);
    d = 8'($random(seed));
    wr(OFF_SCRATCH_A, d);
    rd(OFF_SCRATCH_A, d);
    wr(OFF_INT_HI_ALIAS, d);
    rd(OFF_INT_HI, d);
    wr(OFF_INT_HI, RST_HIGH_LIMIT);
    wr(OFF_INT_LO_ALIAS, d);
    rd(OFF_INT_LO, d);
    wr(OFF_INT_LO, 8'h00);
    rd(OFF_INT_LO_ALIAS, 8'h00);
    wr(OFF_E1_HI_FRAC, 8'hFF);
    rd(OFF_E1_HI_FRAC, 8'hE0);
    wr(OFF_E1_HI_FRAC, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 24; i++)
    begin
      t = {16'($random(seed)), 32'($random(seed))};
      if (i == 0)
        t = 48'h5520_5520_0000;
      if (i == 1)
        t = 48'h0000_0000_5600;
      // Internal limits are whole degrees, but its reading has a fraction
      cx = {hot(t[15:8], t[7:0], 8'h55), hot(t[31:24], t[23:16], 8'h55),
            hot(t[47:40], t[39:32], 8'h55)};
      lx = {hot(t[15:8], t[7:0], 8'h00), hot(t[31:24], t[23:16], 8'h00),
            hot(t[47:40], t[39:32], 8'h00)};
      i_conv.convert(t, 2'h0);
      #1;
      chk("alert", {7'h0, ~(|cx | ~&lx)}, {7'h0, alertN});
      chk("crit", {5'h0, cx}, {5'h0, ext2CriticalFlag, ext1CriticalFlag,
          internalCriticalFlag});
      chk("shutdown", 8'h01, {7'h0, systemShutdownN});
      rd(OFF_STATUS, {3'h0, |cx, ~&lx, 1'h0, |cx, 1'h0});
    end
    $display("test compare done");
    for (int k = 0; k < 7; k++)
    begin
      wr(OFF_LINK_CFG, LK[k]);
      i_conv.convert({TV[k][23:16], 8'h0, TV[k][15:8], 8'h0,
                      TV[k][7:0], 8'h0}, 2'h0);
      #1;
      chk("shutdown", {7'h0, SDX[k]}, {7'h0, systemShutdownN});
    end
    wr(OFF_LINK_CFG, 8'h00);
    @(posedge clk_sys) hwShutdownCond <= 1'h1;
    @(posedge clk_sys);
    #1;
    chk("hw shutdown", 8'h00, {7'h0, systemShutdownN});
    @(posedge clk_sys) hwShutdownCond <= 1'h0;
    $display("test shutdown done");
    resetn <= 1'h0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'h1;
    rd(OFF_SCRATCH_A, RST_SCRATCH);
    rd(OFF_INT_HI, RST_HIGH_LIMIT);
    $display("test mid reset done");
    i_conv.convert(48'h3000_3000_3000, 2'h2);
    #1;
    chk("alert", 8'h00, {7'h0, alertN});
    rd(OFF_STATUS, 8'h04);
    rd(OFF_FAULT_SRC, 8'h04);
    rd(OFF_FAULT_SRC, 8'h00);
    $display("test fault done");
    conclude();
  end

  initial
  begin
    // Sequence needs about two hundred cycles
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    conclude();
  end
endmodule

`default_nettype wire
